// >>> common/rtp_pkg.sv
package rtp_pkg;
  // ==========================================
  // bus framing
  localparam logic [7:0] SLV_ADDR_BYTE = 8'hd0;
  localparam int NUM_REGS = 8;
  localparam int PTR_W = 3;
  localparam logic [PTR_W-1:0] PTR_ONE = 3'h1;
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] BIT_LAST = 4'h7;
  // ==========================================
  // byte roles seen by the device
  localparam logic [1:0] K_DEV = 2'h0;
  localparam logic [1:0] K_WORD = 2'h1;
  localparam logic [1:0] K_DATA = 2'h2;
  // ==========================================
  // host command word: {stop_after, op[1:0], byte[7:0]}
  localparam int CMD_W = 11;
  localparam int CMD_STOP_BIT = 10;
  localparam int CMD_OP_LSB = 8;
  localparam logic [1:0] OP_START_WR = 2'h0;
  localparam logic [1:0] OP_WR = 2'h1;
  localparam logic [1:0] OP_RD_ACK = 2'h2;
  localparam logic [1:0] OP_RD_NACK = 2'h3;
  // ==========================================
  // timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int SCL_PERIOD_NS = 2500;
  localparam int QTR_CYC = (SCL_PERIOD_NS + 4 * CLK_PERIOD_NS - 1) / (4 * CLK_PERIOD_NS);
  localparam logic [1:0] Q_SET = 2'h0;
  localparam logic [1:0] Q_RISE = 2'h1;
  localparam logic [1:0] Q_MID = 2'h2;
  localparam logic [1:0] Q_FALL = 2'h3;
  // ==========================================
  // state machines
  typedef enum logic [5:0] {
    S_IDLE = 6'b000001,
    S_RX = 6'b000010,
    S_ACK = 6'b000100,
    S_TX = 6'b001000,
    S_MACK = 6'b010000,
    S_SKIP = 6'b100000
  } rtp_dev_state_t;
  typedef enum logic [3:0] {
    M_WAIT = 4'b0001,
    M_START = 4'b0010,
    M_BIT = 4'b0100,
    M_STOP = 4'b1000
  } rtp_host_state_t;
endpackage

// >>> common/rtp_if.sv
interface rtp_if;
  logic m_scl_o;
  logic m_scl_oe;
  logic m_sda_o;
  logic m_sda_oe;
  logic s_sda_o;
  logic s_sda_oe;
  logic scl;
  logic sda;
  // ==========================================
  // open-drain wired-and with pull-ups
  assign scl = ~(m_scl_oe & ~m_scl_o);
  assign sda = ~((m_sda_oe & ~m_sda_o) | (s_sda_oe & ~s_sda_o));
  modport dev (input scl, input sda, output s_sda_o, output s_sda_oe);
  modport host (input scl, input sda, output m_scl_o, output m_scl_oe, output m_sda_o, output m_sda_oe);
endinterface

// >>> logic/rtp_fifo2.sv
module rtp_fifo2 #(
  parameter int W = 8,
  parameter int DEPTH = 2
) (
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  if (DEPTH < 2 || DEPTH != (1 << AW))
  begin : g_bad_depth
    $error("fifo depth must be a power of two, at least 2");
  end
  logic [W-1:0] mem_r [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0] cnt_r;
  logic push;
  logic pop;
  assign in_ready_o = cnt_r != (AW + 1)'(DEPTH);
  assign out_valid_o = cnt_r != '0;
  assign out_data_o = mem_r[rd_ptr_r];
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;
  always_ff @(posedge ref_clk_i)
  begin
    if (push)
      mem_r[wr_ptr_r] <= in_data_i;
  end
  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      cnt_r <= '0;
    end
    else
    begin
      if (push)
        wr_ptr_r <= wr_ptr_r + 1'b1;
      if (pop)
        rd_ptr_r <= rd_ptr_r + 1'b1;
      if (push && !pop)
        cnt_r <= cnt_r + 1'b1;
      else if (pop && !push)
        cnt_r <= cnt_r - 1'b1;
    end
  end
endmodule

// >>> logic/rtp_master.sv
module rtp_master #(
  parameter int QTR_CYC = rtp_pkg::QTR_CYC,
  parameter int DEPTH = 2
) (
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  rtp_if.host link,
  input wire logic cmd_valid_i,
  output logic cmd_ready_o,
  input wire logic [rtp_pkg::CMD_W-1:0] cmd_data_i,
  output logic rx_valid_o,
  output logic [7:0] rx_data_o,
  output logic rx_nack_o,
  output logic idle_o
);
  localparam int QW = $clog2(QTR_CYC + 1);
  if (QTR_CYC < 1)
  begin : g_bad_qtr
    $error("quarter period must be at least one cycle");
  end
  // ==========================================
  // pin sampling and quarter-bit divider
  logic [1:0] scl_sync_r;
  logic [1:0] sda_sync_r;
  logic [QW-1:0] div_r;
  logic tick;
  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      scl_sync_r <= 2'h3;
      sda_sync_r <= 2'h3;
      div_r <= '0;
    end
    else
    begin
      scl_sync_r <= {scl_sync_r[0], link.scl};
      sda_sync_r <= {sda_sync_r[0], link.sda};
      div_r <= tick ? '0 : div_r + 1'b1;
    end
  end
  assign tick = div_r == QW'(QTR_CYC - 1);
  // ==========================================
  // command buffer, lets the user run ahead of the bus
  logic f_valid;
  logic f_pop;
  logic [rtp_pkg::CMD_W-1:0] f_data;
  rtp_fifo2 #(.W(rtp_pkg::CMD_W), .DEPTH(DEPTH)) u_cmd (
    .ref_clk_i(ref_clk_i),
    .rst_b_i(rst_b_i),
    .in_valid_i(cmd_valid_i),
    .in_ready_o(cmd_ready_o),
    .in_data_i(cmd_data_i),
    .out_valid_o(f_valid),
    .out_ready_i(f_pop),
    .out_data_o(f_data)
  );
  // ==========================================
  // bit engine
  rtp_pkg::rtp_host_state_t state_r;
  logic [1:0] q_r;
  logic [3:0] bit_r;
  logic [1:0] op_r;
  logic stop_r;
  logic [7:0] txsh_r;
  logic [7:0] rxsh_r;
  logic scl_oe_r;
  logic sda_oe_r;
  logic is_wr;
  logic bus_free;
  assign is_wr = op_r == rtp_pkg::OP_START_WR || op_r == rtp_pkg::OP_WR;
  // an idle bus is only seized when both lines read high
  assign bus_free = scl_oe_r | (scl_sync_r[1] & sda_sync_r[1]);
  assign f_pop = state_r == rtp_pkg::M_WAIT && tick && f_valid && bus_free;
  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      state_r <= rtp_pkg::M_WAIT;
      q_r <= '0;
      bit_r <= '0;
      op_r <= '0;
      stop_r <= 1'b0;
      txsh_r <= '0;
      rxsh_r <= '0;
      scl_oe_r <= 1'b0;
      sda_oe_r <= 1'b0;
      rx_valid_o <= 1'b0;
      rx_data_o <= '0;
      rx_nack_o <= 1'b0;
    end
    else
    begin
      rx_valid_o <= 1'b0;
      if (tick)
      begin
        q_r <= q_r + 2'h1;
        case (state_r)
          rtp_pkg::M_WAIT:
          begin
            q_r <= '0;
            if (f_pop)
            begin
              op_r <= f_data[rtp_pkg::CMD_OP_LSB +: 2];
              stop_r <= f_data[rtp_pkg::CMD_STOP_BIT];
              txsh_r <= f_data[7:0];
              bit_r <= '0;
              state_r <= (f_data[rtp_pkg::CMD_OP_LSB +: 2] == rtp_pkg::OP_START_WR) ? rtp_pkg::M_START
                                                                                     : rtp_pkg::M_BIT;
            end
          end
          rtp_pkg::M_START:
          begin
            case (q_r)
              rtp_pkg::Q_SET: sda_oe_r <= 1'b0;
              rtp_pkg::Q_RISE: scl_oe_r <= 1'b0;
              rtp_pkg::Q_MID: sda_oe_r <= 1'b1;
              default:
              begin
                scl_oe_r <= 1'b1;
                state_r <= rtp_pkg::M_BIT;
              end
            endcase
          end
          rtp_pkg::M_BIT:
          begin
            case (q_r)
              rtp_pkg::Q_SET:
                if (bit_r == rtp_pkg::BITS_PER_BYTE)
                  sda_oe_r <= !is_wr && op_r == rtp_pkg::OP_RD_ACK;
                else
                  sda_oe_r <= is_wr & ~txsh_r[7];
              rtp_pkg::Q_RISE: scl_oe_r <= 1'b0;
              rtp_pkg::Q_MID:
                if (bit_r == rtp_pkg::BITS_PER_BYTE)
                  rx_nack_o <= sda_sync_r[1];
                else
                  rxsh_r <= {rxsh_r[6:0], sda_sync_r[1]};
              default:
              begin
                scl_oe_r <= 1'b1;
                txsh_r <= txsh_r << 1;
                bit_r <= bit_r + 4'h1;
                if (bit_r == rtp_pkg::BITS_PER_BYTE)
                begin
                  rx_valid_o <= 1'b1;
                  rx_data_o <= rxsh_r;
                  state_r <= stop_r ? rtp_pkg::M_STOP : rtp_pkg::M_WAIT;
                end
              end
            endcase
          end
          rtp_pkg::M_STOP:
          begin
            case (q_r)
              rtp_pkg::Q_SET: sda_oe_r <= 1'b1;
              rtp_pkg::Q_RISE: scl_oe_r <= 1'b0;
              rtp_pkg::Q_MID: sda_oe_r <= 1'b0;
              default: state_r <= rtp_pkg::M_WAIT;
            endcase
          end
          default: state_r <= rtp_pkg::M_WAIT;
        endcase
      end
    end
  end
  assign link.m_scl_o = 1'b0;
  assign link.m_sda_o = 1'b0;
  assign link.m_scl_oe = scl_oe_r;
  assign link.m_sda_oe = sda_oe_r;
  assign idle_o = state_r == rtp_pkg::M_WAIT && !scl_oe_r && !f_valid;
endmodule

// >>> logic/rtp_slave.sv
// Contract
// - answer only own address after START
// - eight registers, seconds through control, in order
// - pointer advances after each data byte; code does not advance it after an unacknowledged read byte
// - register values kept in BCD form
// - master starts only on idle bus
// - data stable while clock high
// - START is data falling, clock high
// - STOP is data rising, clock high
// - one clock per bit, change when low
// - START opens, STOP closes, no byte limit
// - eight bits then receiver drives acknowledge
// - device acknowledges every received byte
// - master acknowledges read bytes except last
// - acknowledge held low through clock high
// - master ends read by withholding acknowledge
// - release data after unacknowledged byte
// - first written byte loads the pointer
// - read pointer advances only on acknowledge
// - read without word address uses pointer
module rtp_slave (
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  rtp_if.dev link,
  input wire logic cal_we_i,
  input wire logic [rtp_pkg::PTR_W-1:0] cal_addr_i,
  input wire logic [7:0] cal_data_i,
  input wire logic [rtp_pkg::PTR_W-1:0] rd_addr_i,
  output logic [7:0] rd_data_o,
  output logic wr_stb_o,
  output logic [rtp_pkg::PTR_W-1:0] wr_addr_o,
  output logic [7:0] wr_data_o,
  output logic addressed_o
);
  // ==========================================
  // pin sampling and bus conditions
  logic [1:0] scl_sync_r;
  logic [1:0] sda_sync_r;
  logic scl_prev_r;
  logic sda_prev_r;
  logic scl_s;
  logic sda_s;
  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      scl_sync_r <= 2'h3;
      sda_sync_r <= 2'h3;
      scl_prev_r <= 1'b1;
      sda_prev_r <= 1'b1;
    end
    else
    begin
      scl_sync_r <= {scl_sync_r[0], link.scl};
      sda_sync_r <= {sda_sync_r[0], link.sda};
      scl_prev_r <= scl_sync_r[1];
      sda_prev_r <= sda_sync_r[1];
    end
  end
  assign scl_s = scl_sync_r[1];
  assign sda_s = sda_sync_r[1];
  logic start_det;
  logic stop_det;
  logic scl_rise;
  logic scl_fall;
  // a data edge inside clock-high is a condition, never a bit
  assign start_det = scl_s & scl_prev_r & sda_prev_r & ~sda_s;
  assign stop_det = scl_s & scl_prev_r & ~sda_prev_r & sda_s;
  assign scl_rise = scl_s & ~scl_prev_r;
  assign scl_fall = ~scl_s & scl_prev_r;
  // ==========================================
  // register file
  logic [7:0] regs_r [rtp_pkg::NUM_REGS];
  logic [rtp_pkg::PTR_W-1:0] ptr_r;
  logic [rtp_pkg::PTR_W-1:0] ptr_inc;
  rtp_pkg::rtp_dev_state_t state_r;
  logic [1:0] kind_r;
  logic [3:0] cnt_r;
  logic [7:0] shift_r;
  logic rw_r;
  logic acked_r;
  logic sda_oe_r;
  logic byte_done;
  logic bus_wr;
  // three-bit pointer wraps from control back to seconds
  assign ptr_inc = ptr_r + rtp_pkg::PTR_ONE;
  assign byte_done = state_r == rtp_pkg::S_RX && scl_fall && cnt_r == rtp_pkg::BITS_PER_BYTE;
  assign bus_wr = byte_done && kind_r == rtp_pkg::K_DATA && !start_det && !stop_det;
  // bytes are stored as sent; the calendar side owns BCD encoding
  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      for (int i = 0; i < rtp_pkg::NUM_REGS; i++)
        regs_r[i] <= rtp_pkg::REG_RST;
    end
    else if (bus_wr)
      regs_r[ptr_r] <= shift_r;
    else if (cal_we_i)
      regs_r[cal_addr_i] <= cal_data_i;
  end
  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      rd_data_o <= '0;
      wr_stb_o <= 1'b0;
      wr_addr_o <= '0;
      wr_data_o <= '0;
    end
    else
    begin
      rd_data_o <= regs_r[rd_addr_i];
      wr_stb_o <= bus_wr;
      if (bus_wr)
      begin
        wr_addr_o <= ptr_r;
        wr_data_o <= shift_r;
      end
    end
  end
  // ==========================================
  // protocol engine
  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      state_r <= rtp_pkg::S_IDLE;
      kind_r <= rtp_pkg::K_DEV;
      cnt_r <= '0;
      shift_r <= '0;
      rw_r <= 1'b0;
      acked_r <= 1'b0;
      sda_oe_r <= 1'b0;
      ptr_r <= '0;
    end
    else if (start_det)
    begin
      // pointer deliberately untouched so a repeated start reads on from it
      state_r <= rtp_pkg::S_RX;
      kind_r <= rtp_pkg::K_DEV;
      cnt_r <= '0;
      sda_oe_r <= 1'b0;
    end
    else if (stop_det)
    begin
      state_r <= rtp_pkg::S_IDLE;
      sda_oe_r <= 1'b0;
    end
    else
    begin
      case (state_r)
        rtp_pkg::S_RX:
        begin
          if (scl_rise)
          begin
            shift_r <= {shift_r[6:0], sda_s};
            cnt_r <= cnt_r + 4'h1;
          end
          else if (byte_done)
          begin
            cnt_r <= '0;
            if (kind_r == rtp_pkg::K_DEV && shift_r[7:1] != rtp_pkg::SLV_ADDR_BYTE[7:1])
              state_r <= rtp_pkg::S_SKIP;
            else
            begin
              state_r <= rtp_pkg::S_ACK;
              sda_oe_r <= 1'b1;
            end
            if (kind_r == rtp_pkg::K_DEV)
              rw_r <= shift_r[0];
            if (kind_r == rtp_pkg::K_WORD)
              ptr_r <= shift_r[rtp_pkg::PTR_W-1:0];
            if (kind_r == rtp_pkg::K_DATA)
              ptr_r <= ptr_inc;
          end
        end
        rtp_pkg::S_ACK:
        begin
          if (scl_fall)
          begin
            if (kind_r == rtp_pkg::K_DEV && rw_r)
            begin
              state_r <= rtp_pkg::S_TX;
              shift_r <= regs_r[ptr_r];
              sda_oe_r <= ~regs_r[ptr_r][7];
            end
            else
            begin
              state_r <= rtp_pkg::S_RX;
              sda_oe_r <= 1'b0;
              kind_r <= (kind_r == rtp_pkg::K_DEV) ? rtp_pkg::K_WORD : rtp_pkg::K_DATA;
            end
          end
        end
        rtp_pkg::S_TX:
        begin
          if (scl_fall)
          begin
            if (cnt_r == rtp_pkg::BIT_LAST)
            begin
              state_r <= rtp_pkg::S_MACK;
              sda_oe_r <= 1'b0;
              cnt_r <= '0;
            end
            else
            begin
              shift_r <= shift_r << 1;
              sda_oe_r <= ~shift_r[6];
              cnt_r <= cnt_r + 4'h1;
            end
          end
        end
        rtp_pkg::S_MACK:
        begin
          if (scl_rise)
            acked_r <= ~sda_s;
          else if (scl_fall)
          begin
            if (acked_r)
            begin
              ptr_r <= ptr_inc;
              shift_r <= regs_r[ptr_inc];
              sda_oe_r <= ~regs_r[ptr_inc][7];
              state_r <= rtp_pkg::S_TX;
            end
            else
              state_r <= rtp_pkg::S_SKIP;
          end
        end
        rtp_pkg::S_IDLE: state_r <= rtp_pkg::S_IDLE;
        rtp_pkg::S_SKIP: state_r <= rtp_pkg::S_SKIP;
        default: state_r <= rtp_pkg::S_IDLE;
      endcase
    end
  end
  assign link.s_sda_o = 1'b0;
  assign link.s_sda_oe = sda_oe_r;
  assign addressed_o = state_r != rtp_pkg::S_IDLE && state_r != rtp_pkg::S_SKIP;
endmodule

// >>> test/rtp_monitor.sv
module rtp_monitor (
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic m_scl_o,
  input wire logic m_scl_oe,
  input wire logic m_sda_o,
  input wire logic m_sda_oe,
  input wire logic s_sda_o,
  input wire logic s_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  timeunit 1ns;
  timeprecision 100ps;
  logic scl_r;
  logic sda_r;
  logic [3:0] cnt_r;
  logic [7:0] adr_r;
  logic start;
  logic rise;
  logic own;
  assign start = scl & scl_r & sda_r & ~sda;
  assign rise = scl & ~scl_r;
  assign own = adr_r[7:1] == rtp_pkg::SLV_ADDR_BYTE[7:1];
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_b_i);
  // ==========================================
  // line history
  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      scl_r <= 1'b1;
      sda_r <= 1'b1;
    end
    else
    begin
      scl_r <= scl;
      sda_r <= sda;
    end
  end
  // ==========================================
  // address byte tracker, saturates so data bytes are not mistaken for addresses
  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      cnt_r <= 4'h0;
      adr_r <= 8'h00;
    end
    else if (start)
    begin
      cnt_r <= 4'h0;
    end
    else if (rise && cnt_r != 4'h9)
    begin
      cnt_r <= cnt_r + 4'h1;
      if (cnt_r < 4'h8)
        adr_r <= {adr_r[6:0], sda};
    end
  end
  // ==========================================
  // checks
  // slave may only pull once all eight address bits have passed
  property p_ack_low;
    s_sda_oe |-> !sda && !s_sda_o && cnt_r >= 4'h8;
  endproperty
  a_ack_low: assert property (p_ack_low) else $error("slave drive not low or too early");
  property p_dev_chg;
    $changed(s_sda_oe) |-> !scl;
  endproperty
  a_dev_chg: assert property (p_dev_chg) else $error("slave data changed with clock high");
  property p_ack_hold;
    ($rose(scl) && s_sda_oe) |-> s_sda_oe [*8];
  endproperty
  a_ack_hold: assert property (p_ack_hold) else $error("slave low not held in clock high");
  property p_own_ack;
    (rise && cnt_r == 4'h8 && own) |-> s_sda_oe;
  endproperty
  a_own_ack: assert property (p_own_ack) else $error("own address not acknowledged");
  property p_foreign;
    (cnt_r >= 4'h8 && !own) |-> !s_sda_oe;
  endproperty
  a_foreign: assert property (p_foreign) else $error("slave drove after foreign address");
  property p_start_host;
    (scl && $past(scl) && $fell(sda)) |-> m_sda_oe;
  endproperty
  a_start_host: assert property (p_start_host) else $error("start not made by host");
  property p_stop_rel;
    (scl && $past(scl) && $rose(sda)) |-> !s_sda_oe && !$past(s_sda_oe, 8) && !m_sda_oe;
  endproperty
  a_stop_rel: assert property (p_stop_rel) else $error("stop with data still pulled");
  property p_scl_high;
    $fell(m_scl_oe) |-> !m_scl_oe [*8];
  endproperty
  a_scl_high: assert property (p_scl_high) else $error("clock high too short");
  property p_idle_gap;
    (scl && $past(scl) && $rose(sda)) |-> (scl && sda && !m_scl_o && !m_sda_o) [*8];
  endproperty
  a_idle_gap: assert property (p_idle_gap) else $error("bus not idle after stop");
endmodule

// >>> test/rtc_two_wire_slave_port_test.sv
module rtc_two_wire_slave_port_test;
  timeunit 1ns;
  timeprecision 100ps;
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin bad_count++; \
  $display("ERROR t=%0t got %h exp %h", $time, a, b); end end
  logic ref_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic cmd_valid_i = 1'b0;
  logic [10:0] cmd_data_i = 11'h000;
  logic cal_we_i = 1'b0;
  logic [2:0] cal_addr_i = 3'h0;
  logic [7:0] cal_data_i = 8'h00;
  logic [2:0] rd_addr_i = 3'h0;
  logic cmd_ready_o;
  logic rx_valid_o;
  logic [7:0] rx_data_o;
  logic rx_nack_o;
  logic idle_o;
  logic [7:0] rd_data_o;
  logic wr_stb_o;
  logic [2:0] wr_addr_o;
  logic [7:0] wr_data_o;
  logic addressed_o;
  int bad_count = 0;
  int samples_checked = 0;
  logic [8:0] rxq[$];
  logic aq[$];
  logic [10:0] wrq[$];
  logic [10:0] cq[$];
  logic [10:0] rows [8] = '{11'h059, 11'h134, 11'h223, 11'h307, 11'h431, 11'h512, 11'h699, 11'h780};
  rtp_if link_if ();
  rtp_slave rtp_slave_inst (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .link(link_if), .cal_we_i(cal_we_i),
    .cal_addr_i(cal_addr_i), .cal_data_i(cal_data_i), .rd_addr_i(rd_addr_i), .rd_data_o(rd_data_o),
    .wr_stb_o(wr_stb_o), .wr_addr_o(wr_addr_o), .wr_data_o(wr_data_o), .addressed_o(addressed_o));
  // small quarter keeps each byte near 300 cycles
  rtp_master #(.QTR_CYC(8), .DEPTH(2)) rtp_master_inst (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
    .link(link_if), .cmd_valid_i(cmd_valid_i), .cmd_ready_o(cmd_ready_o), .cmd_data_i(cmd_data_i),
    .rx_valid_o(rx_valid_o), .rx_data_o(rx_data_o), .rx_nack_o(rx_nack_o), .idle_o(idle_o));
  rtp_monitor rtp_monitor_inst (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .m_scl_o(link_if.m_scl_o),
    .m_scl_oe(link_if.m_scl_oe), .m_sda_o(link_if.m_sda_o), .m_sda_oe(link_if.m_sda_oe),
    .s_sda_o(link_if.s_sda_o), .s_sda_oe(link_if.s_sda_oe), .scl(link_if.scl), .sda(link_if.sda));
  always #2 ref_clk_i = ~ref_clk_i;
  // ==========================================
  // capture pulses at the falling edge, clear of the launching edge
  always @(negedge ref_clk_i)
  begin
    if (rx_valid_o === 1'b1)
    begin
      rxq.push_back({rx_nack_o, rx_data_o});
      aq.push_back(addressed_o);
    end
    if (wr_stb_o === 1'b1)
      wrq.push_back({wr_addr_o, wr_data_o});
  end
  task finish_test;
    $display("bad_count %0d samples_checked %0d", bad_count, samples_checked);
    if (bad_count == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task put(input logic s, input logic [1:0] op, input logic [7:0] b);
    cq.push_back({s, op, b});
  endtask
  // valid stays up between commands, so it is never set twice in one step
  task go(input int nrx);
    int n;
    n = 0;
    rxq.delete();
    wrq.delete();
    aq.delete();
    while (cq.size() > 0)
    begin
      cmd_valid_i = 1'b1;
      cmd_data_i = cq.pop_front();
      while (cmd_ready_o !== 1'b1 && n < 20000)
      begin
        @(posedge ref_clk_i);
        #1;
        n++;
      end
      @(posedge ref_clk_i);
      #1;
    end
    cmd_valid_i = 1'b0;
    while (!(idle_o === 1'b1 && rxq.size() == nrx) && n < 20000)
    begin
      @(posedge ref_clk_i);
      #1;
      n++;
    end
    if (n >= 20000)
    begin
      bad_count++;
      finish_test();
    end
  endtask
  // ==========================================
  // main sequence
  initial
  begin
    repeat (5) @(posedge ref_clk_i);
    #1;
    `CHK(link_if.scl & link_if.sda, 1'b1)
    `CHK(addressed_o, 1'b0)
    repeat (5) @(posedge ref_clk_i);
    #1;
    rst_b_i = 1'b1;
    repeat (3) @(posedge ref_clk_i);
    #1;
    put(1'b0, rtp_pkg::OP_START_WR, 8'hd1);
    put(1'b1, rtp_pkg::OP_RD_NACK, 8'hff);
    go(2);
    `CHK(rxq[0], 9'h0d1)
    `CHK(aq[0], 1'b1)
    `CHK(rxq[1], {1'b1, rtp_pkg::REG_RST})
    for (int i = 0; i < 8; i++)
    begin
      put(1'b0, rtp_pkg::OP_START_WR, rtp_pkg::SLV_ADDR_BYTE);
      put(1'b0, rtp_pkg::OP_WR, {5'h00, rows[i][10:8]});
      put(1'b1, rtp_pkg::OP_WR, rows[i][7:0]);
      go(3);
      `CHK({rxq[0][8], rxq[1][8], rxq[2][8]}, 3'h0)
      `CHK(wrq[0], rows[i])
      put(1'b0, rtp_pkg::OP_START_WR, rtp_pkg::SLV_ADDR_BYTE);
      put(1'b0, rtp_pkg::OP_WR, {5'h00, rows[i][10:8]});
      put(1'b0, rtp_pkg::OP_START_WR, 8'hd1);
      put(1'b1, rtp_pkg::OP_RD_NACK, 8'hff);
      go(4);
      `CHK(rxq[3], {1'b1, rows[i][7:0]})
      rd_addr_i = rows[i][10:8];
      @(posedge ref_clk_i);
      #1;
      `CHK(rd_data_o, rows[i][7:0])
    end
    put(1'b0, rtp_pkg::OP_START_WR, rtp_pkg::SLV_ADDR_BYTE);
    put(1'b0, rtp_pkg::OP_WR, 8'h06);
    put(1'b0, rtp_pkg::OP_WR, 8'h11);
    put(1'b0, rtp_pkg::OP_WR, 8'h22);
    put(1'b1, rtp_pkg::OP_WR, 8'h33);
    go(5);
    `CHK(wrq[0], 11'h611)
    `CHK(wrq[1], 11'h722)
    `CHK(wrq[2], 11'h033)
    put(1'b0, rtp_pkg::OP_START_WR, 8'hd1);
    put(1'b0, rtp_pkg::OP_RD_ACK, 8'hff);
    put(1'b0, rtp_pkg::OP_RD_ACK, 8'hff);
    put(1'b1, rtp_pkg::OP_RD_NACK, 8'hff);
    go(4);
    `CHK(rxq[1], 9'h034)
    `CHK(rxq[2], 9'h023)
    `CHK(rxq[3], 9'h107)
    put(1'b1, rtp_pkg::OP_START_WR, 8'ha0);
    go(1);
    `CHK(rxq[0], 9'h1a0)
    `CHK(aq[0], 1'b0)
    put(1'b0, rtp_pkg::OP_START_WR, 8'hd1);
    put(1'b1, rtp_pkg::OP_RD_NACK, 8'hff);
    go(2);
    `CHK(rxq[1], 9'h107)
    cal_we_i = 1'b1;
    cal_addr_i = 3'h5;
    cal_data_i = 8'h42;
    @(posedge ref_clk_i);
    #1;
    cal_we_i = 1'b0;
    rd_addr_i = 3'h5;
    @(posedge ref_clk_i);
    #1;
    `CHK(rd_data_o, 8'h42)
    // ==========================================
    // reset in mid-run clears registers and pointer
    rst_b_i = 1'b0;
    repeat (2) @(posedge ref_clk_i);
    #1;
    `CHK({addressed_o, idle_o, cmd_ready_o, rd_data_o}, 11'h300)
    rst_b_i = 1'b1;
    repeat (3) @(posedge ref_clk_i);
    #1;
    `CHK(rd_data_o, rtp_pkg::REG_RST)
    put(1'b0, rtp_pkg::OP_START_WR, 8'hd1);
    put(1'b1, rtp_pkg::OP_RD_NACK, 8'hff);
    go(2);
    `CHK(rxq[1], {1'b1, rtp_pkg::REG_RST})
    finish_test();
  end
endmodule
